// ==== design/pulse_gate_pkg.sv ====
// ---------------------------------------------------------------------
// Shared constants for the fault and brown-out pulse gate
// ---------------------------------------------------------------------
package pulse_gate_pkg;

  // Nominal fault delay in microseconds, as printed
  localparam int FAULT_TIME_US      = 15000;
  // Nominal switching frequency in kHz, used to turn time into periods
  localparam int SW_FREQ_KHZ        = 125;
  // Switching periods before an overload latches
  localparam int FAULT_PERIODS      = (FAULT_TIME_US * SW_FREQ_KHZ) / 1000;
  // Width of the fault timer
  localparam int FAULT_TIMER_W      = $clog2(FAULT_PERIODS + 1);
  // Clean periods needed before the fault timer is cleared
  localparam int CLEAN_PERIODS      = 3;
  // Width of the clean-period counter
  localparam int CLEAN_W            = $clog2(CLEAN_PERIODS + 1);
  // Reset value of every control flip-flop
  localparam logic CTRL_RESET_VALUE = 1'b0;

endpackage

// ==== design/period_counter.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Saturating period counter with terminal flag
// ---------------------------------------------------------------------
module period_counter #(
  parameter int WIDTH = 4,
  parameter int LIMIT = 3
) (
  input  wire logic             sysClk,   // Block clock
  input  wire logic             rstN,     // Synchronised reset, active low
  input  wire logic             clear,    // Return count to zero
  input  wire logic             advance,  // Count one period
  output logic      [WIDTH-1:0] count,    // Current count
  output logic                  done      // Count has reached the limit
);

  // Terminal value at counter width
  localparam logic [WIDTH-1:0] TERMINAL = WIDTH'(LIMIT);

  // Step decode
  wire             atLimit   = (count == TERMINAL);
  wire [WIDTH-1:0] countNext = count + WIDTH'(1);

  assign done = atLimit;

  // Clear dominates, count stops at the limit
  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (advance && !atLimit) begin
      count <= countNext;
    end
  end

endmodule

// ==== design/fault_and_brownout_pulse_gate.sv ====
`timescale 1ns/1ps
module fault_and_brownout_pulse_gate (
  input  wire logic sys_clk,               // Block clock, 25 MHz
  input  wire logic reset_n,               // Asynchronous reset, active low
  input  wire logic brownoutAboveRef,      // Sense input above brownout_reference
  input  wire logic csAtMax,               // Current sense at its 1 V maximum
  input  wire logic oscPhase,              // Oscillator phase, rises once a period
  input  wire logic pwmRequest,            // Gate request from the PWM latch
  input  wire logic vccAtTurnOff,          // Supply down at turn-off threshold
  output logic      gateDrive,             // Gate drive output
  output logic      rampSwitchClosed,      // Ramp to compensation resistor switch
  output logic      hysteresisSinkEnable,  // hysteresis_sink_current on
  output logic      softStartGround,       // Soft-start pin held to ground
  output logic      softStartRestart,      // One-cycle request for a new soft start
  output logic      faultTimerActive,      // Overload seen, timer counting
  output logic      faultLatched           // Permanent overload latch
);

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic rstMeta;  // First reset stage
  logic rstSync;  // Released reset used everywhere

  // Two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta <= pulse_gate_pkg::CTRL_RESET_VALUE;
      rstSync <= pulse_gate_pkg::CTRL_RESET_VALUE;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // -------------------------------------------------------------------
  // Period tick and brown-out decode
  // -------------------------------------------------------------------
  logic oscPrev;        // Previous oscillator phase
  logic boLowPrev;      // Previous brown-out state
  logic periodHadFault; // Limit hit during the current period

  wire periodTick     = oscPhase & ~oscPrev;
  wire boLow          = ~brownoutAboveRef;            // Includes external shutdown
  wire boRelease      = boLowPrev & ~boLow;           // Input recovered
  wire faultReset     = boLow | vccAtTurnOff;
  wire periodFault    = periodHadFault | csAtMax;     // Fault in this period
  wire cleanDone;                                     // Three clean periods seen
  wire timerDone;                                     // Fault timer expired
  wire [pulse_gate_pkg::CLEAN_W-1:0]       cleanCount; // Clean periods so far
  wire [pulse_gate_pkg::FAULT_TIMER_W-1:0] timerCount; // Periods under fault

  // Counter controls; a fresh hit clears the clean count at once, so a
  // stale count of three cannot drop the timer right after a new hit
  wire cleanClear   = faultReset | ~faultTimerActive | csAtMax |
                      (periodTick & periodFault);
  wire cleanAdvance = periodTick & ~periodFault;
  wire timerClear   = faultReset | ~faultTimerActive;
  wire timerAdvance = periodTick & faultTimerActive;

  // Next state decode
  wire next_faultTimerActive = ~faultReset & ~faultLatched &
                               (csAtMax | (faultTimerActive & ~cleanDone));
  wire next_faultLatched     = ~faultReset &
                               (faultLatched | (faultTimerActive & timerDone));
  wire next_gateDrive        = pwmRequest & ~boLow & ~faultLatched &
                               ~next_faultLatched;

  // -------------------------------------------------------------------
  // Counters
  // -------------------------------------------------------------------
  // Clean periods before the timer may clear
  period_counter #(
    .WIDTH (pulse_gate_pkg::CLEAN_W),
    .LIMIT (pulse_gate_pkg::CLEAN_PERIODS)
  ) cleanCounter (
    .sysClk  (sys_clk),
    .rstN    (rstSync),
    .clear   (cleanClear),
    .advance (cleanAdvance),
    .count   (cleanCount),
    .done    (cleanDone)
  );

  // Overload duration in switching periods
  period_counter #(
    .WIDTH (pulse_gate_pkg::FAULT_TIMER_W),
    .LIMIT (pulse_gate_pkg::FAULT_PERIODS)
  ) faultTimer (
    .sysClk  (sys_clk),
    .rstN    (rstSync),
    .clear   (timerClear),
    .advance (timerAdvance),
    .count   (timerCount),
    .done    (timerDone)
  );

  // -------------------------------------------------------------------
  // Edge history
  // -------------------------------------------------------------------
  // Oscillator and brown-out history
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      oscPrev   <= pulse_gate_pkg::CTRL_RESET_VALUE;
      boLowPrev <= pulse_gate_pkg::CTRL_RESET_VALUE;
    end else begin
      oscPrev   <= oscPhase;
      boLowPrev <= boLow;
    end
  end

  // Per-period fault memory, a new hit wins over the tick clear
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      periodHadFault <= pulse_gate_pkg::CTRL_RESET_VALUE;
    end else if (csAtMax) begin
      periodHadFault <= 1'b1;
    end else if (periodTick) begin
      periodHadFault <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Fault state
  // -------------------------------------------------------------------
  // Overload timer flag and permanent latch
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      faultTimerActive <= pulse_gate_pkg::CTRL_RESET_VALUE;
      faultLatched     <= pulse_gate_pkg::CTRL_RESET_VALUE;
    end else begin
      faultTimerActive <= next_faultTimerActive;
      faultLatched     <= next_faultLatched;
    end
  end

  // -------------------------------------------------------------------
  // Pin outputs
  // -------------------------------------------------------------------
  // Gate, ramp switch, sink and soft-start control
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      gateDrive            <= pulse_gate_pkg::CTRL_RESET_VALUE;
      rampSwitchClosed     <= pulse_gate_pkg::CTRL_RESET_VALUE;
      hysteresisSinkEnable <= pulse_gate_pkg::CTRL_RESET_VALUE;
      softStartGround      <= pulse_gate_pkg::CTRL_RESET_VALUE;
      softStartRestart     <= pulse_gate_pkg::CTRL_RESET_VALUE;
    end else begin
      gateDrive            <= next_gateDrive;
      rampSwitchClosed     <= next_gateDrive;
      hysteresisSinkEnable <= boLow;
      softStartGround      <= boLow;
      softStartRestart     <= boRelease;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstSync);

  gate_off_bo_a:      assert property (boLow |=> !gateDrive)
    else $error("gate pulsed during brown-out");
  restart_pulse_a:    assert property ($fell(boLow) |=>
    softStartRestart ##1 !softStartRestart)
    else $error("no single restart pulse after recovery");
  restart_cause_a:    assert property (softStartRestart |->
    $past(boLow, 2) && !hysteresisSinkEnable)
    else $error("restart pulse without a recovery");
  gate_sink_excl_a:   assert property (gateDrive |-> !hysteresisSinkEnable)
    else $error("gate on while sink shows brown-out");
  sink_on_a:          assert property (boLow |=> hysteresisSinkEnable)
    else $error("sink off while below reference");
  sink_off_a:         assert property (!boLow |=> !hysteresisSinkEnable)
    else $error("sink on while above reference");
  fault_arm_a:        assert property (csAtMax && !faultReset && !faultLatched |=>
    faultTimerActive)
    else $error("limit hit did not arm fault timer");
  latch_block_a:      assert property (faultLatched |-> !gateDrive)
    else $error("gate pulsed with fault latched");
  latch_hold_a:       assert property (faultLatched && !faultReset |=> faultLatched)
    else $error("fault latch dropped without reset condition");
  clean_clear_a:      assert property (cleanDone && !csAtMax && !faultReset |=>
    !faultTimerActive)
    else $error("timer not cleared after clean periods");
  fault_period_a:     assert property (periodTick && periodFault |=> cleanCount == 2'h0)
    else $error("clean count kept across a faulty period");
  hit_clean_clear_a:  assert property (csAtMax |=> cleanCount == '0)
    else $error("clean count kept after a fresh hit");
  fault_clear_a:      assert property (faultReset |=> !faultLatched && !faultTimerActive)
    else $error("fault latch survived reset condition");
  ramp_gate_a:        assert property (rampSwitchClosed == gateDrive)
    else $error("ramp switch differs from gate");
  timer_expire_a:     assert property (timerDone && faultTimerActive && !faultReset |=>
    faultLatched)
    else $error("timer expiry did not latch fault");
  ss_ground_a:        assert property (boLow ##1 boLow |-> softStartGround)
    else $error("soft-start released during brown-out");
  ss_release_a:       assert property (!boLow |=> !softStartGround)
    else $error("soft-start held low above reference");
  counter_reset_a:    assert property (faultReset |=> timerCount == '0 && cleanCount == '0)
    else $error("counters not cleared by fault reset");
  timer_idle_a:       assert property (!faultTimerActive |=> timerCount == '0)
    else $error("fault timer kept count while idle");

  // Cover points for the main scenarios
  latch_seen_c:       cover property ($rose(faultLatched));
  restart_seen_c:     cover property ($rose(softStartRestart));
  clean_seen_c:       cover property (faultTimerActive ##1 !faultTimerActive && !faultLatched);
  release_seen_c:     cover property (faultLatched ##1 !faultLatched);

endmodule

// ==== verif/pulse_gate_partner.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Far side: oscillator, sense comparators, shutdown pull-down
// ---------------------------------------------------------------------
module pulse_gate_partner (
  input  wire logic sysClk,            // Bench clock
  input  wire logic ticking,           // Run the oscillator
  input  wire logic overload,          // Primary current at its limit
  input  wire logic shutdown,          // External pull-down on sense pin
  output logic      oscPhase,          // Two-clock switching period
  output logic      csAtMax,           // Current comparator result
  output logic      brownoutAboveRef   // Brown-out comparator result
);
  // Far-side states, quiet at time zero
  logic oscQ = 1'b0;  // Oscillator phase
  logic csQ  = 1'b0;  // Current comparator
  logic boQ  = 1'b1;  // Brown-out comparator, input healthy
  // Comparators follow commands one clock later
  always @(posedge sysClk) begin
    oscQ <= ticking & ~oscQ;
    csQ  <= overload;
    boQ  <= ~shutdown;
  end
  assign oscPhase         = oscQ;
  assign csAtMax          = csQ;
  assign brownoutAboveRef = boQ;
endmodule

// ==== verif/fault_and_brownout_pulse_gate_tb.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Bench with a cycle model compared at every clock
// ---------------------------------------------------------------------
module fault_and_brownout_pulse_gate_tb;
  localparam int FP = pulse_gate_pkg::FAULT_PERIODS;
  localparam int CP = pulse_gate_pkg::CLEAN_PERIODS;
  logic sysClk = 1'b0, resetN = 1'b0, pwmRequest = 1'b0, vccAtTurnOff = 1'b0;
  logic ticking = 1'b0, overload = 1'b0, shutdown = 1'b0;
  wire logic oscPhase, csAtMax, brownoutAboveRef, gateDrive, rampSwitchClosed;
  wire logic hysteresisSinkEnable, softStartGround, softStartRestart;
  wire logic faultTimerActive, faultLatched;
  int fails = 0, nTests = 0, seed = 32'hfc9a2457;
  int mOsc, mPf, mLat, mAct, mCnt, mCln, mSink, tk, pf, fr, nL, nA, eG, eS, eR, eA, eL;
  always #20 sysClk = ~sysClk;
  fault_and_brownout_pulse_gate fault_and_brownout_pulse_gate_inst (
    .sys_clk(sysClk), .reset_n(resetN), .brownoutAboveRef(brownoutAboveRef),
    .csAtMax(csAtMax), .oscPhase(oscPhase), .pwmRequest(pwmRequest),
    .vccAtTurnOff(vccAtTurnOff), .gateDrive(gateDrive),
    .rampSwitchClosed(rampSwitchClosed), .hysteresisSinkEnable(hysteresisSinkEnable),
    .softStartGround(softStartGround), .softStartRestart(softStartRestart),
    .faultTimerActive(faultTimerActive), .faultLatched(faultLatched));
  pulse_gate_partner pulse_gate_partner_inst (
    .sysClk(sysClk), .ticking(ticking), .overload(overload), .shutdown(shutdown),
    .oscPhase(oscPhase), .csAtMax(csAtMax), .brownoutAboveRef(brownoutAboveRef));
  // Compare one output with its expected level
  task chk(input string nm, input logic got, input int exp);
    nTests++;
    if (got !== exp[0]) begin
      fails++;
      $display("ERROR %s expected %0d seen %b", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task conclude;
    if (fails == 0 && nTests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Let n edges pass, then stop where outputs have settled
  task hold(input int n);
    repeat (n) @(posedge sysClk);
    @(negedge sysClk);
  endtask
  // Model: check last prediction, then predict from inputs of next edge
  always @(negedge sysClk) begin
    if (!resetN) begin
      {mOsc, mPf, mLat, mAct, mCnt, mCln, mSink, eG, eS, eR, eA, eL} = '0;
    end else begin
      chk("gateDrive", gateDrive, eG);
      chk("rampSwitchClosed", rampSwitchClosed, eG);
      chk("hysteresisSinkEnable", hysteresisSinkEnable, eS);
      chk("softStartGround", softStartGround, eS);
      chk("softStartRestart", softStartRestart, eR);
      chk("faultTimerActive", faultTimerActive, eA);
      chk("faultLatched", faultLatched, eL);
      // Next state from the present state and the inputs of the coming edge
      tk = oscPhase && !mOsc;
      pf = mPf || csAtMax;
      fr = !brownoutAboveRef || vccAtTurnOff;
      nL = !fr && (mLat != 0 || (mAct != 0 && mCnt == FP));
      nA = !fr && mLat == 0 && (csAtMax || (mAct != 0 && mCln != CP));
      if (fr || mAct == 0) mCnt = 0;
      else if (tk && mCnt < FP) mCnt++;
      if (fr || mAct == 0 || csAtMax || (tk && pf)) mCln = 0;
      else if (tk && mCln < CP) mCln++;
      mPf = csAtMax ? 1 : (tk ? 0 : mPf);
      mOsc = oscPhase;
      eG = pwmRequest && brownoutAboveRef && mLat == 0 && !nL;
      eR = brownoutAboveRef && mSink != 0;
      mSink = !brownoutAboveRef;
      {mLat, mAct} = {nL, nA};
      {eS, eA, eL} = {mSink, mAct, mLat};
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge sysClk);
    resetN <= 1'b1;
    repeat (4) @(posedge sysClk);
    ticking <= 1'b1;
    // Random traffic
    repeat (400) begin
      @(posedge sysClk);
      pwmRequest <= ($random(seed) & 1) != 0;
      overload <= ($random(seed) & 7) == 0;
      shutdown <= ($random(seed) & 31) == 0;
      vccAtTurnOff <= ($random(seed) & 63) == 0;
    end
    // Steady overload runs the timer out
    @(posedge sysClk);
    {overload, shutdown, vccAtTurnOff, pwmRequest} <= 4'b1001;
    hold(2 * FP + 20);
    chk("faultLatched", faultLatched, 1);
    @(posedge sysClk);
    overload <= 1'b0;
    hold(20);
    chk("gateDrive", gateDrive, 0);
    chk("faultLatched", faultLatched, 1);
    // Shutdown through the sense pin clears it
    @(posedge sysClk);
    shutdown <= 1'b1;
    hold(5);
    chk("softStartGround", softStartGround, 1);
    @(posedge sysClk);
    shutdown <= 1'b0;
    hold(5);
    chk("faultLatched", faultLatched, 0);
    // Short overload, then clean periods
    @(posedge sysClk);
    overload <= 1'b1;
    hold(20);
    chk("faultTimerActive", faultTimerActive, 1);
    @(posedge sysClk);
    overload <= 1'b0;
    hold(12);
    chk("faultTimerActive", faultTimerActive, 0);
    // Latch again, clear by supply drop
    @(posedge sysClk);
    overload <= 1'b1;
    hold(2 * FP + 20);
    chk("faultLatched", faultLatched, 1);
    @(posedge sysClk);
    {overload, vccAtTurnOff} <= 2'b01;
    hold(3);
    @(posedge sysClk);
    vccAtTurnOff <= 1'b0;
    hold(5);
    chk("faultLatched", faultLatched, 0);
    conclude;
  end
  // Watchdog against a hang
  initial begin
    repeat (4 * FP + 3000) @(posedge sysClk);
    fails++;
    conclude;
  end
endmodule
